// ---- rtl/fepcp_top.sv ----
// transceiver control, loop-back, negotiation, pause timer, leds, axi4-lite registers
`timescale 1ns/1ps
module fepcp_top
  import fepcp_pkg::*;
#(
  parameter int SLOT10_CYCLES = SLOT10_CYC,
  parameter int FLP_CYCLES = FLP_CYC,
  parameter int BLINK_CYCLES = BLINK20_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bit_stb_i,
  input wire logic rx_line_i,
  input wire logic tx_nrz_i,
  input wire logic tx_en_i,
  input wire logic link_ok_i,
  input wire fepcp_ctl_t ctl_i,
  input wire fepcp_lp_t lp_i,
  output logic [1:0] tx_mlt3_o,
  output logic tx_line_en_o,
  output logic [4:0] rx_grp_o,
  output logic rx_grp_stb_o,
  output logic crs_o,
  output logic col_o,
  output logic flp_o,
  output logic flp_active_o,
  output logic pause_o,
  output logic tx_grant_o,
  output logic [3:0] led_o,
  output logic phy_rst_o
);

  if (SLOT10_CYCLES < 2 || SLOT10_CYCLES > 65535 || FLP_CYCLES < 1 ||
      FLP_CYCLES > 65535 || BLINK_CYCLES < 1 || BLINK_CYCLES > 33554431) begin : g_chk
    $error("fepcp_top: timing parameter out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave and registers
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [15:0] basic_q, basic_d, advert_q, advert_d, vendor_q, vendor_d;
  logic srst_d;
  logic do_wr;
  fepcp_status_t st;
  logic [15:0] timer_q, timer_d, lp_q, lp_d;
  logic an_done, res_fd, res_spd, pause_en;
  logic pause_q, pause_d;

  assign do_wr = aw_got_q && w_got_q && !s_axi_bvalid;

  always_comb begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = s_axi_bvalid && !s_axi_bready;
    bresp_d = s_axi_bresp;
    basic_d = basic_q;
    advert_d = advert_q;
    vendor_d = vendor_q;
    srst_d = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = 2'b00;
      unique case (awaddr_q)
        BASIC_OFS: begin
          if (wstrb_q[0]) basic_d[7:0] = wdata_q[7:0];
          if (wstrb_q[1]) basic_d[15:8] = wdata_q[15:8];
          srst_d = wstrb_q[1] && wdata_q[BC_RST_BIT];
        end
        ADVERT_OFS: begin
          if (wstrb_q[0]) advert_d[7:0] = wdata_q[7:0];
          if (wstrb_q[1]) advert_d[15:8] = wdata_q[15:8];
        end
        VENDOR_OFS: begin
          if (wstrb_q[0]) vendor_d[7:0] = wdata_q[7:0];
          if (wstrb_q[1]) vendor_d[15:8] = wdata_q[15:8];
        end
        PARTNER_OFS, STATUS_OFS: ;
        default: bresp_d = 2'b10;
      endcase
    end
    if (phy_rst_o) begin
      basic_d = BASIC_RST;
      advert_d = ADVERT_RST;
      vendor_d = VENDOR_RST;
    end
  end

  assign st = '{rsvd: 11'h000, pause_en: pause_en, an_done: an_done,
                spd100: res_spd, fd: res_fd, paused: pause_q};

  always_comb begin
    rvalid_d = s_axi_rvalid && !s_axi_rready;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = 2'b00;
      unique case (s_axi_araddr)
        BASIC_OFS: rdata_d = {16'h0000, basic_q};
        ADVERT_OFS: rdata_d = {16'h0000, advert_q};
        PARTNER_OFS: rdata_d = {16'h0000, lp_q};
        VENDOR_OFS: rdata_d = {16'h0000, vendor_q};
        STATUS_OFS: rdata_d = {timer_q, st};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = 2'b10;
        end
      endcase
    end
  end

  // readiness is derived from next state so a held channel never sees a stale ready
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      basic_q <= BASIC_RST;
      advert_q <= ADVERT_RST;
      vendor_q <= VENDOR_RST;
      phy_rst_o <= 1'b0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= !aw_got_d && !bvalid_d;
      s_axi_wready <= !w_got_d && !bvalid_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= !rvalid_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
      basic_q <= basic_d;
      advert_q <= advert_d;
      vendor_q <= vendor_d;
      phy_rst_o <= srst_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // line coding and loop-back
  logic rx_meta_q, rx_sync_q;
  logic stb_q, tx_nrzi_q, tx_nrzi_d, man_q, man_d, half_q, half_d;
  logic rx_prev_q, rx_prev_d, rx_nrz_q, rx_nrz_d, rx_src;
  logic mlt_prev_q, mlt_prev_d, mlt_in;
  logic [1:0] mlt_idx_q, mlt_idx_d, mlt3_d;
  logic nrzi_code_enable, int_lb, rlb_act, rx_crs;

  assign nrzi_code_enable = vendor_q[VC_NRZI_BIT];
  assign int_lb = basic_q[BC_LB_BIT];
  assign rlb_act = vendor_q[VC_RLB_BIT] && res_spd && !int_lb;
  assign rx_src = int_lb ? (res_spd ? tx_nrzi_q : man_q) : rx_sync_q;
  assign mlt_in = rlb_act ? rx_sync_q : tx_nrzi_q;

  always_comb begin
    tx_nrzi_d = tx_nrzi_q;
    man_d = man_q;
    half_d = half_q;
    rx_prev_d = rx_prev_q;
    rx_nrz_d = rx_nrz_q;
    mlt_prev_d = mlt_prev_q;
    mlt_idx_d = mlt_idx_q;
    if (bit_stb_i) begin
      tx_nrzi_d = nrzi_code_enable ? tx_nrzi_q ^ tx_nrz_i : tx_nrz_i;
      half_d = !half_q;
      man_d = tx_nrz_i ^ half_q;
      rx_prev_d = rx_src;
      rx_nrz_d = nrzi_code_enable ? rx_src ^ rx_prev_q : rx_src;
      mlt_prev_d = mlt_in;
      if (mlt_in != mlt_prev_q) begin
        mlt_idx_d = mlt_idx_q + 2'h1;
      end
    end
    unique case (mlt_idx_q)
      2'h1: mlt3_d = 2'b01;
      2'h3: mlt3_d = 2'b11;
      default: mlt3_d = 2'b00;
    endcase
  end

  // the line pin passes two flops before anything looks at it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_meta_q <= 1'b0;
      rx_sync_q <= 1'b0;
      stb_q <= 1'b0;
      tx_nrzi_q <= 1'b0;
      man_q <= 1'b0;
      half_q <= 1'b0;
      rx_prev_q <= 1'b0;
      rx_nrz_q <= 1'b1;
      mlt_prev_q <= 1'b0;
      mlt_idx_q <= 2'h0;
      tx_mlt3_o <= 2'b00;
      tx_line_en_o <= 1'b0;
    end else begin
      rx_meta_q <= rx_line_i;
      rx_sync_q <= rx_meta_q;
      stb_q <= bit_stb_i;
      tx_nrzi_q <= tx_nrzi_d;
      man_q <= man_d;
      half_q <= half_d;
      rx_prev_q <= rx_prev_d;
      rx_nrz_q <= rx_nrz_d;
      mlt_prev_q <= mlt_prev_d;
      mlt_idx_q <= mlt_idx_d;
      tx_mlt3_o <= mlt3_d;
      tx_line_en_o <= !int_lb;
    end
  end

  fepcp_rx_carrier u_carrier (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .bit_stb_i(stb_q),
    .nrz_i(rx_nrz_q),
    .grp_o(rx_grp_o),
    .grp_stb_o(rx_grp_stb_o),
    .crs_o(rx_crs)
  );

  //////////////////////////////////////////////////////////////////////////////
  // auto-negotiation
  fepcp_an_t an_q, an_d;
  logic pend_q, pend_d, autoneg_enable_prev_q;
  logic [15:0] flp_cnt_q, flp_cnt_d;
  logic [3:0] idx_q, idx_d;
  logic [15:0] common;

  assign common = advert_q & lp_q;
  assign an_done = (an_q == AN_DONE) && basic_q[BC_AN_BIT];

  always_comb begin
    res_spd = basic_q[BC_SPD_BIT];
    res_fd = basic_q[BC_FD_BIT];
    if (an_done) begin
      res_spd = common[AD_100F_BIT] || common[AD_100H_BIT];
      res_fd = common[AD_100F_BIT] ||
               (!common[AD_100H_BIT] && common[AD_10F_BIT]);
    end
  end

  always_comb begin
    an_d = an_q;
    pend_d = pend_q || (basic_q[BC_AN_BIT] && !autoneg_enable_prev_q);
    flp_cnt_d = flp_cnt_q;
    idx_d = idx_q;
    lp_d = lp_q;
    unique case (an_q)
      AN_IDLE, AN_DONE: begin
        if (!basic_q[BC_AN_BIT]) begin
          an_d = AN_IDLE;
        end else if (pend_q) begin
          an_d = AN_SEND;
          pend_d = 1'b0;
          flp_cnt_d = 16'h0000;
          idx_d = 4'h0;
        end
      end
      AN_SEND: begin
        if (flp_cnt_q == 16'(FLP_CYCLES - 1)) begin
          flp_cnt_d = 16'h0000;
          idx_d = idx_q + 4'h1;
          if (idx_q == 4'(AN_BITS - 1)) begin
            an_d = AN_WAIT;
          end
        end else begin
          flp_cnt_d = flp_cnt_q + 16'h0001;
        end
      end
      AN_WAIT: begin
        if (!basic_q[BC_AN_BIT]) begin
          an_d = AN_IDLE;
        end else if (lp_i.valid) begin
          lp_d = lp_i.word;
          an_d = AN_DONE;
        end
      end
    endcase
    if (phy_rst_o) begin
      an_d = AN_IDLE;
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      an_q <= AN_IDLE;
      pend_q <= 1'b1;
      autoneg_enable_prev_q <= 1'b1;
      flp_cnt_q <= 16'h0000;
      idx_q <= 4'h0;
      lp_q <= 16'h0000;
      flp_o <= 1'b0;
      flp_active_o <= 1'b0;
    end else begin
      an_q <= an_d;
      pend_q <= pend_d;
      autoneg_enable_prev_q <= basic_q[BC_AN_BIT];
      flp_cnt_q <= flp_cnt_d;
      idx_q <= idx_d;
      lp_q <= lp_d;
      flp_o <= (an_d == AN_SEND) && advert_q[idx_d];
      flp_active_o <= (an_d == AN_SEND);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pause timer; tx_grant_o drops the cycle after a pause loads, even while tx_en_i shows a frame on the wire
  logic [15:0] slot_q, slot_d, slot_lim;
  logic is_pause;

  assign pause_en = an_done && res_fd && advert_q[AD_PAUSE_BIT] &&
                    lp_q[AD_PAUSE_BIT];
  assign is_pause = ctl_i.valid && (ctl_i.opcode == PAUSE_OPCODE) && pause_en;
  assign slot_lim = res_spd ? 16'(SLOT100_CYC - 1) : 16'(SLOT10_CYCLES - 1);

  always_comb begin
    pause_d = pause_q;
    timer_d = timer_q;
    slot_d = slot_q;
    if (is_pause) begin
      slot_d = 16'h0000;
      timer_d = ctl_i.param;
      pause_d = (ctl_i.param != 16'h0000);
    end else if (pause_q) begin
      if (slot_q == slot_lim) begin
        slot_d = 16'h0000;
        timer_d = timer_q - 16'h0001;
        pause_d = (timer_q != 16'h0001);
      end else begin
        slot_d = slot_q + 16'h0001;
      end
    end
    if (phy_rst_o || !pause_en) begin
      pause_d = 1'b0;
      timer_d = 16'h0000;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pause_q <= 1'b0;
      timer_q <= 16'h0000;
      slot_q <= 16'h0000;
      pause_o <= 1'b0;
      tx_grant_o <= 1'b1;
    end else begin
      pause_q <= pause_d;
      timer_q <= timer_d;
      slot_q <= slot_d;
      pause_o <= pause_d;
      tx_grant_o <= !pause_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // carrier, collision and leds
  logic [24:0] blink_q, blink_d;
  logic b20_q, b20_d, b10_q, b10_d;
  logic crs_d, col_d;
  logic [3:0] led_d;

  always_comb begin
    crs_d = res_fd ? rx_crs : (rx_crs || tx_en_i);
    col_d = !res_fd && rx_crs && tx_en_i;
    blink_d = blink_q + 25'h0000001;
    b20_d = b20_q;
    b10_d = b10_q;
    if (blink_q == 25'(BLINK_CYCLES - 1)) begin
      blink_d = 25'h0000000;
      b20_d = !b20_q;
      b10_d = b10_q ^ b20_q;
    end
    if (!vendor_q[VC_LED_BIT]) begin
      led_d[0] = res_spd;
      led_d[1] = link_ok_i && (crs_o && !col_o ? b10_q : 1'b1);
      led_d[2] = col_o ? b20_q : res_fd;
      led_d[3] = 1'b0;
    end else begin
      led_d[0] = link_ok_i && res_spd;
      led_d[1] = link_ok_i && !res_spd;
      led_d[2] = crs_o && b10_q;
      led_d[3] = col_o ? b20_q : res_fd;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      crs_o <= 1'b0;
      col_o <= 1'b0;
      blink_q <= 25'h0000000;
      b20_q <= 1'b0;
      b10_q <= 1'b0;
      led_o <= 4'h0;
    end else begin
      crs_o <= crs_d;
      col_o <= col_d;
      blink_q <= blink_d;
      b20_q <= b20_d;
      b10_q <= b10_d;
      led_o <= led_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  nrzi_bypass_a: assert property (bit_stb_i && !nrzi_code_enable |=> rx_nrz_q == $past(rx_src))
    else $error("nrzi bypass not honoured");
  crs_full_a: assert property (res_fd && !rx_crs |=> !crs_o)
    else $error("carrier shown in full duplex without receive");
  col_full_a: assert property (res_fd |=> !col_o)
    else $error("collision shown in full duplex");
  lb_isolate_a: assert property (int_lb |=> !tx_line_en_o)
    else $error("line driven during internal loop-back");
  flp_end_a: assert property (an_q == AN_SEND && idx_q == 4'hf &&
      flp_cnt_q == 16'(FLP_CYCLES - 1) && !phy_rst_o |=> an_q == AN_WAIT)
    else $error("burst did not end after sixteen bits");
  pause_load_a: assert property (is_pause && ctl_i.param != 16'h0000 && !phy_rst_o
      |=> pause_o && !tx_grant_o && timer_q == $past(ctl_i.param))
    else $error("pause not loaded");
  pause_zero_a: assert property (is_pause && ctl_i.param == 16'h0000 |=> !pause_o)
    else $error("zero pause did not release");
  srst_self_a: assert property (phy_rst_o |=> !phy_rst_o && basic_q == BASIC_RST)
    else $error("soft reset did not restore or clear");

  pause_seen_c: cover property (is_pause ##1 pause_o);
  an_done_c: cover property (an_q == AN_WAIT ##1 an_q == AN_DONE);
  loop_int_c: cover property (int_lb && stb_q);

endmodule

// ---- rtl/fepcp_pkg.sv ----
// shared constants and types for the transceiver control and pause block
//////////////////////////////////////////////////////////////////////////////
package fepcp_pkg;

  // register byte addresses
  localparam logic [7:0] BASIC_OFS = 8'h00;
  localparam logic [7:0] ADVERT_OFS = 8'h04;
  localparam logic [7:0] PARTNER_OFS = 8'h08;
  localparam logic [7:0] VENDOR_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // basic_phy_control_reg fields
  localparam int BC_RST_BIT = 15;
  localparam int BC_LB_BIT = 14;
  localparam int BC_SPD_BIT = 13;
  localparam int BC_AN_BIT = 12;
  localparam int BC_FD_BIT = 8;
  // vendor_phy_control_reg fields
  localparam int VC_RLB_BIT = 9;
  localparam int VC_NRZI_BIT = 7;
  localparam int VC_LED_BIT = 0;
  // advert_reg / partner_ability_reg fields
  localparam int AD_10H_BIT = 5;
  localparam int AD_10F_BIT = 6;
  localparam int AD_100H_BIT = 7;
  localparam int AD_100F_BIT = 8;
  localparam int AD_PAUSE_BIT = 10;

  localparam logic [15:0] BASIC_RST = 16'h3100;
  localparam logic [15:0] ADVERT_RST = 16'h05e1;
  localparam logic [15:0] VENDOR_RST = 16'h0080;

  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [4:0] GRP_IDLE = 5'h1f;
  localparam logic [4:0] GRP_END_T = 5'h0d;
  localparam logic [2:0] GRP_LAST = 3'h4;
  localparam int AN_BITS = 16;

  // timing
  localparam int CLK_NS = 10;
  localparam int SLOT_BITS = 512;
  localparam int BIT100_NS = 10;
  localparam int BIT10_NS = 100;
  localparam int SLOT100_CYC = SLOT_BITS * BIT100_NS / CLK_NS;
  localparam int SLOT10_CYC = SLOT_BITS * BIT10_NS / CLK_NS;
  localparam int FLP_BIT_NS = 62500;
  localparam int FLP_CYC = FLP_BIT_NS / CLK_NS;
  localparam int BLINK20_HALF_NS = 25000000;
  localparam int BLINK20_CYC = BLINK20_HALF_NS / CLK_NS;

  typedef enum logic [1:0] {
    AN_IDLE = 2'b00,
    AN_SEND = 2'b01,
    AN_WAIT = 2'b10,
    AN_DONE = 2'b11
  } fepcp_an_t;

  typedef struct packed {
    logic valid;
    logic [15:0] opcode;
    logic [15:0] param;
  } fepcp_ctl_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } fepcp_lp_t;

  typedef struct packed {
    logic [10:0] rsvd;
    logic pause_en;
    logic an_done;
    logic spd100;
    logic fd;
    logic paused;
  } fepcp_status_t;

endpackage

// ---- rtl/fepcp_rx_carrier.sv ----
// receive carrier detect and 5-bit group packing
`timescale 1ns/1ps
module fepcp_rx_carrier
  import fepcp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic bit_stb_i,
  input wire logic nrz_i,
  output logic [4:0] grp_o,
  output logic grp_stb_o,
  output logic crs_o
);

  logic [9:0] win_q, win_d;
  logic [2:0] cnt_q, cnt_d;
  logic [4:0] grp_d;
  logic stb_d, crs_d;

  function automatic logic two_zeros(input logic [9:0] w);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      for (int j = i + 2; j < 10; j++) begin
        if (!w[i] && !w[j]) begin
          hit = 1'b1;
        end
      end
    end
    return hit;
  endfunction

  always_comb begin
    win_d = win_q;
    cnt_d = cnt_q;
    grp_d = grp_o;
    stb_d = 1'b0;
    crs_d = crs_o;
    if (bit_stb_i) begin
      win_d = {win_q[8:0], nrz_i};
      cnt_d = (cnt_q == GRP_LAST) ? 3'h0 : cnt_q + 3'h1;
      if (!crs_o && two_zeros(win_d)) begin
        crs_d = 1'b1;
        cnt_d = 3'h0;
      end else if (cnt_q == GRP_LAST) begin
        stb_d = 1'b1;
        grp_d = win_d[4:0];
        if (win_d[4:0] == GRP_IDLE || win_d[4:0] == GRP_END_T) begin
          crs_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_q <= 10'h3ff;
      cnt_q <= 3'h0;
      grp_o <= 5'h00;
      grp_stb_o <= 1'b0;
      crs_o <= 1'b0;
    end else begin
      win_q <= win_d;
      cnt_q <= cnt_d;
      grp_o <= grp_d;
      grp_stb_o <= stb_d;
      crs_o <= crs_d;
    end
  end

endmodule

// ---- tb/fepcp_link_partner.sv ----
// link partner model: answers negotiation and sends control frames
`timescale 1ns/1ps
module fepcp_link_partner
  import fepcp_pkg::*;
#(
  parameter int DLY = 3
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic flp_active_i,
  input wire logic [15:0] ability_i,
  input wire logic send_i,
  input wire logic [15:0] op_i,
  input wire logic [15:0] par_i,
  output fepcp_lp_t lp_o,
  output fepcp_ctl_t ctl_o
);
  logic flp_q;
  logic [7:0] cnt_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flp_q <= 1'b0;
      cnt_q <= 8'h00;
      lp_o <= '0;
      ctl_o <= '0;
    end else begin
      flp_q <= flp_active_i;
      // a larger DLY models a slow partner
      if (flp_q && !flp_active_i) begin
        cnt_q <= 8'(DLY);
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
      // ability word sent once our burst ends; both sides resolve alike
      lp_o.valid <= (cnt_q == 8'h01);
      // idle word toggles so a stale value is never mistaken for data
      lp_o.word <= (cnt_q == 8'h01) ? ability_i : ~lp_o.word;
      // every frame requested on send_i is handed over one cycle later, with no address filter
      ctl_o.valid <= send_i;
      ctl_o.opcode <= send_i ? op_i : ~ctl_o.opcode;
      ctl_o.param <= send_i ? par_i : ~ctl_o.param;
    end
  end
endmodule

// ---- tb/fast_ethernet_phy_ctrl_pause_tb_top.sv ----
// self-checking bench for the transceiver control and pause block
`timescale 1ns/1ps
module fast_ethernet_phy_ctrl_pause_tb_top;
  import fepcp_pkg::*;
  logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, send = 0, z = 0;
  logic stb = 0, txe = 0, run = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd;
  logic [15:0] op = 0, par = 0;
  logic [1:0] resp;
  wire logic awr, wr, bv, arr, rv;
  wire logic [1:0] brs, rrs;
  wire logic [31:0] rdat;
  wire logic flp_act, pause, grant, line_en, prst;
  wire logic crs, col, flp;
  wire logic [3:0] led;
  fepcp_lp_t lp;
  fepcp_ctl_t ctl;
  int n_fail = 0, checks_done = 0;
  localparam int FLP_N = 4;
  always #5 clk = ~clk;
  // one line bit every other cycle while run is high
  always @(posedge clk) stb <= run && !stb;
  fepcp_top #(.SLOT10_CYCLES(8), .FLP_CYCLES(FLP_N), .BLINK_CYCLES(4)) dut_u (
    .core_clk_i(clk), .rst_i(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rr), .bit_stb_i(stb),
    .rx_line_i(z), .tx_nrz_i(z), .tx_en_i(txe), .link_ok_i(z), .ctl_i(ctl), .lp_i(lp),
    .tx_mlt3_o(), .tx_line_en_o(line_en), .rx_grp_o(), .rx_grp_stb_o(), .crs_o(crs),
    .col_o(col), .flp_o(flp), .flp_active_o(flp_act), .pause_o(pause), .tx_grant_o(grant),
    .led_o(led), .phy_rst_o(prst));
  fepcp_link_partner #(.DLY(3)) partner_u (
    .core_clk_i(clk), .rst_i(rst), .flp_active_i(flp_act), .ability_i(ADVERT_RST),
    .send_i(send), .op_i(op), .par_i(par), .lp_o(lp), .ctl_o(ctl));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
    end while (!(bv && br) && n < 100);
    if (n >= 100) begin
      n_fail++;
      $display("mismatch at %0t: write got no response", $time);
    end
    resp = brs;
    br <= 0;
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a; arv <= 1; rr <= 1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 0;
    end while (!(rv && rr) && n < 100);
    if (n >= 100) begin
      n_fail++;
      $display("mismatch at %0t: read got no response", $time);
    end
    rd = rdat;
    resp = rrs;
    rr <= 0;
  endtask
  task automatic pause_frame(input logic [15:0] o, input logic [15:0] p);
    @(posedge clk);
    send <= 1; op <= o; par <= p;
    @(posedge clk);
    send <= 0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    finish_test();
  end
  initial begin
    int n, k;
    repeat (5) @(posedge clk);
    rst <= 0;
    // the burst starts unasked one edge after reset; time it and add up its ones
    n = 0;
    k = 0;
    while (!flp_act && n < 10) begin @(posedge clk); n++; end
    chk(flp_act, 1);
    n = 0;
    while (flp_act && n < 200) begin k += flp; @(posedge clk); n++; end
    chk(n, AN_BITS * FLP_N);
    chk(k, $countones(ADVERT_RST) * FLP_N);
    axr(BASIC_OFS); chk(rd, {16'h0, BASIC_RST});
    axr(VENDOR_OFS); chk(rd, {16'h0, VENDOR_RST});
    axr(8'h14); chk({30'h0, resp}, 32'h2);
    $display("test reset done");
    repeat (8) @(posedge clk);
    axr(STATUS_OFS); chk(rd, 32'h1e);
    $display("test negotiation done");
    pause_frame(16'h0002, 16'h0005); chk({pause, grant}, 2'b01);
    pause_frame(PAUSE_OPCODE, 16'h0003); chk({pause, grant}, 2'b10);
    repeat (2 * SLOT100_CYC) @(posedge clk);
    #1 chk(pause, 1);
    n = 0;
    while (pause && n < 600) begin @(posedge clk); n++; end
    chk(n > 400 && n < 600, 1);
    pause_frame(PAUSE_OPCODE, 16'hffff); chk(pause, 1);
    pause_frame(PAUSE_OPCODE, 16'h0000); chk({pause, grant}, 2'b01);
    $display("test pause done");
    axw(BASIC_OFS, 32'h7100); chk(resp, 0);
    repeat (3) @(posedge clk);
    #1 chk(line_en, 0);
    // internal loop at 100M: a steady zero stream must raise carrier
    @(posedge clk);
    run <= 1;
    n = 0;
    while (!crs && n < 40) begin @(posedge clk); n++; end
    chk(crs, 1);
    txe <= 1;
    repeat (3) @(posedge clk);
    #1 chk(col, 0);
    axw(ADVERT_OFS, 32'h00a1);
    repeat (3) @(posedge clk);
    #1 chk({crs, col, led[0]}, 3'b111);
    axw(VENDOR_OFS, 32'h0000);
    repeat (4) @(posedge clk);
    #1 chk(crs, 1);
    @(posedge clk);
    run <= 0;
    txe <= 0;
    $display("test line done");
    axw(8'h20, 32'h1); chk(resp, 2'b10);
    axw(ADVERT_OFS, 32'h0021);
    repeat (3) @(posedge clk);
    #1 chk(led[0], 0);
    axw(BASIC_OFS, 32'h8000);
    n = 0;
    while (!prst && n < 10) begin @(posedge clk); n++; end
    chk(prst, 1);
    repeat (2) @(posedge clk);
    axr(ADVERT_OFS); chk(rd, {16'h0, ADVERT_RST});
    axr(BASIC_OFS); chk(rd, {16'h0, BASIC_RST});
    $display("test soft reset done");
    finish_test();
  end
endmodule
